// file: core/hub_cfg_pkg.sv
/*
 package for the hub configuration status and strap block.
 assumes a single clk_sys domain at 125 MHz and a synchronous active-low reset.
*/
package hub_cfg_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] CFG_STATUS_CMD_OFFSET  = 8'hF8;
   localparam logic [7:0] CFG_STATUS_CMD_RESET   = 8'h00;
   localparam int         SOFT_RESET_BIT         = 1;
   localparam int         IN_PROGRESS_BIT        = 0;
   localparam logic [7:0] RESERVED_MASK          = 8'hFC;
   // ==========================================================
   // shadow configuration register
   localparam logic [7:0] USER_CFG_OFFSET        = 8'hF0;
   localparam logic [7:0] USER_CFG_RESET         = 8'h00;
   // ==========================================================
   // strap capture and soft reset timing
   localparam int         STRAP_SETTLE_NS        = 64;
   localparam int         CLK_PERIOD_NS          = 8;
   localparam int         STRAP_SETTLE_CYC       =
      (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         SOFT_RESET_CYC         = 4;
   localparam int         NUM_PORTS              = 4;
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_I2C,
      MODE_SMBUS
   } cfg_mode_t;
endpackage

// file: core/sync2.sv
/*
 two flip-flop synchroniser for a vector of pin levels.
 assumes inputs are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   // ==========================================================
   // two stages
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // sync2

// file: core/strap_latch.sv
/*
 captures synchronised strap levels once, a fixed time after reset release.
 assumes straps are stable from before reset release until capture.
*/
`timescale 1ns/1ps
module strap_latch #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   // straps
   input  wire logic [W-1:0] strap_sync,
   output logic      [W-1:0] strap_q,
   output logic              strap_valid
);
   logic [7:0] cnt_r;
   // ==========================================================
   // settle counter then latch
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cnt_r       <= '0;
         strap_valid <= 1'b0;
      end else if (!strap_valid) begin
         if (cnt_r == 8'(hub_cfg_pkg::STRAP_SETTLE_CYC)) begin
            strap_valid <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         strap_q <= '0;
      end else if (!strap_valid && cnt_r == 8'(hub_cfg_pkg::STRAP_SETTLE_CYC)) begin
         strap_q <= strap_sync;
      end
   end
endmodule // strap_latch

// file: core/hub_config_status_and_straps.sv
/*
 configuration status and command register with strap decode for a
 four-port hub. register access comes from the configuration slave logic
 as a simple byte write/read port. straps are asynchronous pins.
*/
`timescale 1ns/1ps
module hub_config_status_and_straps (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   // register access from configuration slave
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // configuration mode from the serial slave
   input  wire logic       cfg_mode_active,
   // strap pins
   input  wire logic       config_interface_select_n,
   input  wire logic       power_switch_polarity_strap,
   input  wire logic       shared_power_switch_strap,
   input  wire logic       full_power_mgmt_strap_n,
   input  wire logic [3:0] port_charge_enable_strap,
   // power request from hub core
   input  wire logic [3:0] port_power_req,
   // outputs
   output logic      [3:0] port_power_enable,
   output logic      [3:0] port_charge_en,
   output logic            shared_power_mode,
   output logic            full_power_mgmt,
   output logic            smbus_mode,
   output logic            upstream_connect_allow,
   output logic            cfg_soft_reset_pulse,
   output logic      [7:0] user_cfg
);
   localparam int NS = 8;
   logic [NS-1:0] strap_sync;
   logic [NS-1:0] strap_q;
   logic          strap_valid;
   logic          soft_rst_r;
   logic [2:0]    soft_cnt_r;
   logic          in_prog_r;
   logic          mode_act_r;
   logic [7:0]    user_cfg_r;
   logic [3:0]    pwr_r;
   logic          wr_status;
   logic          wr_user;
   logic          soft_done;
   hub_cfg_pkg::cfg_mode_t mode_r;
   hub_cfg_pkg::cfg_mode_t mode_nxt;

   // ==========================================================
   // strap synchronisation and capture
   sync2 #(.W(NS)) i_sync2 (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .d       ({port_charge_enable_strap, full_power_mgmt_strap_n,
                 shared_power_switch_strap, power_switch_polarity_strap,
                 config_interface_select_n}),
      .q       (strap_sync)
   );
   strap_latch #(.W(NS)) i_strap_latch (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .strap_sync  (strap_sync),
      .strap_q     (strap_q),
      .strap_valid (strap_valid)
   );

   // ==========================================================
   // strap decode
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         smbus_mode        <= 1'b0;
         shared_power_mode <= 1'b0;
         full_power_mgmt   <= 1'b0;
         port_charge_en    <= 4'h0;
      end else if (strap_valid) begin
         smbus_mode        <= ~strap_q[0];
         shared_power_mode <= strap_q[2];
         full_power_mgmt   <= ~strap_q[3];
         port_charge_en    <= strap_q[7:4];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pwr_r <= 4'h0;
      end else if (shared_power_mode) begin
         pwr_r <= {4{|port_power_req}};
      end else begin
         pwr_r <= port_power_req;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         port_power_enable <= 4'h0;
      end else if (!strap_valid) begin
         port_power_enable <= 4'h0;
      end else if (strap_q[1]) begin
         port_power_enable <= pwr_r;
      end else begin
         port_power_enable <= ~pwr_r;
      end
   end

   // ==========================================================
   // configuration mode tracking
   always_comb begin
      mode_nxt = mode_r;
      unique case (mode_r)
         hub_cfg_pkg::MODE_IDLE: begin
            if (strap_valid && cfg_mode_active) begin
               mode_nxt = smbus_mode ? hub_cfg_pkg::MODE_SMBUS : hub_cfg_pkg::MODE_I2C;
            end
         end
         hub_cfg_pkg::MODE_I2C: begin
            if (!cfg_mode_active) begin
               mode_nxt = hub_cfg_pkg::MODE_IDLE;
            end
         end
         hub_cfg_pkg::MODE_SMBUS: begin
            if (!cfg_mode_active) begin
               mode_nxt = hub_cfg_pkg::MODE_IDLE;
            end
         end
         default: mode_nxt = hub_cfg_pkg::MODE_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mode_r     <= hub_cfg_pkg::MODE_IDLE;
         mode_act_r <= 1'b0;
      end else begin
         mode_r     <= mode_nxt;
         mode_act_r <= (mode_nxt != hub_cfg_pkg::MODE_IDLE);
      end
   end

   // ==========================================================
   // register writes
   assign wr_status = reg_wr && (reg_addr == hub_cfg_pkg::CFG_STATUS_CMD_OFFSET);
   assign wr_user   = reg_wr && (reg_addr == hub_cfg_pkg::USER_CFG_OFFSET);
   assign soft_done = soft_rst_r && (soft_cnt_r == 3'(hub_cfg_pkg::SOFT_RESET_CYC - 1));

   // soft reset command bit
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         soft_rst_r <= hub_cfg_pkg::CFG_STATUS_CMD_RESET[hub_cfg_pkg::SOFT_RESET_BIT];
         soft_cnt_r <= 3'h0;
      end else if (soft_rst_r) begin
         soft_cnt_r <= soft_cnt_r + 3'h1;
         if (soft_done) begin
            soft_rst_r <= 1'b0;
            soft_cnt_r <= 3'h0;
         end
      end else if (wr_status && reg_wdata[hub_cfg_pkg::SOFT_RESET_BIT]
                   && mode_r == hub_cfg_pkg::MODE_SMBUS) begin
         soft_rst_r <= 1'b1;
      end
   end

   assign cfg_soft_reset_pulse = soft_done;

   // configuration in progress flag
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         in_prog_r <= hub_cfg_pkg::CFG_STATUS_CMD_RESET[hub_cfg_pkg::IN_PROGRESS_BIT];
      end else if (soft_done) begin
         in_prog_r <= 1'b1;
      end else if (mode_nxt != hub_cfg_pkg::MODE_IDLE && !mode_act_r) begin
         in_prog_r <= 1'b1;
      end else if (mode_r == hub_cfg_pkg::MODE_I2C && mode_nxt == hub_cfg_pkg::MODE_IDLE) begin
         in_prog_r <= 1'b0;
      end else if (wr_status && reg_wdata[hub_cfg_pkg::IN_PROGRESS_BIT]) begin
         in_prog_r <= 1'b0;
      end
   end

   // shadow configuration register, reloaded by soft reset
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         user_cfg_r <= hub_cfg_pkg::USER_CFG_RESET;
      end else if (soft_done) begin
         user_cfg_r <= hub_cfg_pkg::USER_CFG_RESET;
      end else if (wr_user && !soft_rst_r) begin
         user_cfg_r <= reg_wdata;
      end
   end
   assign user_cfg = user_cfg_r;

   // upstream connect gate
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         upstream_connect_allow <= 1'b0;
      end else begin
         upstream_connect_allow <= strap_valid && !in_prog_r && !mode_act_r
                                   && !soft_rst_r;
      end
   end

   // ==========================================================
   // register reads
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == hub_cfg_pkg::CFG_STATUS_CMD_OFFSET) begin
            reg_rdata <= {6'h00, soft_rst_r, in_prog_r};
         end else if (reg_addr == hub_cfg_pkg::USER_CFG_OFFSET) begin
            reg_rdata <= user_cfg_r;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end
endmodule // hub_config_status_and_straps

// file: dv/cfg_agent.sv
/* configuration agent model: register writes/reads and mode level.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module cfg_agent (
   // clock
   input  wire logic       clk_sys,
   // register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   // mode level
   output logic            cfg_mode_active
);
   initial begin
      {reg_wr, reg_rd, cfg_mode_active} = 3'b000;
      {reg_addr, reg_wdata} = 16'hA5C3;
   end
   // released lines show the inverse value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(posedge clk_sys);
      #1;
      {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      {reg_addr, reg_rd} = {a, 1'b1};
      @(posedge clk_sys);
      #1;
      {reg_addr, reg_rd} = {~a, 1'b0};
      d = reg_rdata;
   endtask
   task automatic mode(input logic on);
      @(posedge clk_sys);
      #1;
      cfg_mode_active = on;
   endtask
   task automatic end_cfg;
      wr(8'hF8, 8'h01);
   endtask
endmodule // cfg_agent

// file: dv/hub_config_status_and_straps_assertions.sv
/* checker for the hub configuration block, bound to its top ports.
   assumes straps only change while resetn is low. */
`timescale 1ns/1ps
module hub_cfg_checker (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       resetn,
   // watched ports
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic       cfg_mode_active,
   input wire logic       config_interface_select_n,
   input wire logic       shared_power_switch_strap,
   input wire logic       full_power_mgmt_strap_n,
   input wire logic [3:0] port_charge_enable_strap,
   input wire logic [3:0] port_charge_en,
   input wire logic       shared_power_mode,
   input wire logic       full_power_mgmt,
   input wire logic       smbus_mode,
   input wire logic       upstream_connect_allow,
   input wire logic       cfg_soft_reset_pulse,
   input wire logic [7:0] user_cfg
);
   // ==========================================================
   // properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_RSVD_ZERO: assert property (
      reg_rd && reg_addr == 8'hF8 |=> reg_rdata[7:2] == 6'h00) else $error("reserved bits set");
   AST_HOLD_OFF: assert property (
      cfg_mode_active |=> ##1 !upstream_connect_allow) else $error("connect during config");
   AST_PULSE_ONE: assert property (
      cfg_soft_reset_pulse |=> !cfg_soft_reset_pulse) else $error("soft reset pulse too long");
   AST_PULSE_SMBUS: assert property (
      cfg_soft_reset_pulse |-> smbus_mode) else $error("soft reset outside smbus mode");
   AST_RELOAD: assert property (
      cfg_soft_reset_pulse |=> user_cfg == 8'h00) else $error("config not reloaded");
   AST_RECONFIG: assert property (
      cfg_soft_reset_pulse |=> ##1 !upstream_connect_allow) else $error("flag not set again");
   AST_SMBUS_STRAP: assert property (
      smbus_mode |-> !config_interface_select_n) else $error("wrong interface mode");
   AST_SHARED: assert property (
      shared_power_mode |-> shared_power_switch_strap) else $error("wrong power grouping");
   AST_FULL_PM: assert property (
      full_power_mgmt |-> !full_power_mgmt_strap_n) else $error("wrong power management");
   AST_CHARGE: assert property (
      port_charge_en != 4'h0 |-> port_charge_en == port_charge_enable_strap)
      else $error("wrong charge enables");
   AST_I2C_EXIT: assert property (
      $fell(cfg_mode_active) && !smbus_mode |-> ##[1:4] upstream_connect_allow)
      else $error("flag not cleared on exit");
   cover property (cfg_soft_reset_pulse);
   cover property ($rose(upstream_connect_allow));
   cover property (smbus_mode && cfg_mode_active);
endmodule // hub_cfg_checker
bind hub_config_status_and_straps hub_cfg_checker i_hub_cfg_checker (.clk_sys, .resetn,
   .reg_rd, .reg_addr, .reg_rdata, .cfg_mode_active, .config_interface_select_n,
   .shared_power_switch_strap, .full_power_mgmt_strap_n, .port_charge_enable_strap,
   .port_charge_en, .shared_power_mode, .full_power_mgmt, .smbus_mode,
   .upstream_connect_allow, .cfg_soft_reset_pulse, .user_cfg);

// file: dv/test_hub_config_status_and_straps.sv
/* self-checking bench for the hub configuration block.
   assumes cfg_agent drives the register port and mode level. */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module test_hub_config_status_and_straps;
   logic       clk_sys = 1'b0;
   logic       resetn, reg_wr, reg_rd, cfg_mode_active, config_interface_select_n;
   logic       power_switch_polarity_strap, shared_power_switch_strap;
   logic       full_power_mgmt_strap_n, shared_power_mode, full_power_mgmt, smbus_mode;
   logic       upstream_connect_allow, cfg_soft_reset_pulse;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, user_cfg, d;
   logic [3:0] port_charge_enable_strap, port_power_req, port_power_enable, port_charge_en;
   int         err_total = 0;
   int         compares = 0;
   always #4 clk_sys = ~clk_sys;
   hub_config_status_and_straps i_hub_config_status_and_straps (.clk_sys, .resetn,
      .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .cfg_mode_active,
      .config_interface_select_n, .power_switch_polarity_strap, .shared_power_switch_strap,
      .full_power_mgmt_strap_n, .port_charge_enable_strap, .port_power_req,
      .port_power_enable, .port_charge_en, .shared_power_mode, .full_power_mgmt,
      .smbus_mode, .upstream_connect_allow, .cfg_soft_reset_pulse, .user_cfg);
   cfg_agent i_cfg_agent (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .cfg_mode_active);
   // ==========================================================
   // tasks
   task automatic results;
      $display("mismatches %0d of %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic rst(input logic [7:0] s);
      resetn = 1'b0;
      @(posedge clk_sys);
      #1;
      {config_interface_select_n, power_switch_polarity_strap, shared_power_switch_strap,
       full_power_mgmt_strap_n, port_charge_enable_strap} = s;
      repeat (11) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      repeat (16) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_i2c;
      rst(8'hC5);
      `CHK(smbus_mode, 1'b0)
      `CHK(shared_power_mode, 1'b0)
      `CHK(full_power_mgmt, 1'b1)
      `CHK(port_charge_en, 4'h5)
      port_power_req = 4'hA;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK(port_power_enable, 4'hA)
      `CHK(upstream_connect_allow, 1'b1)
      i_cfg_agent.mode(1'b1);
      i_cfg_agent.rd(8'hF8, d);
      `CHK(d, 8'h01)
      `CHK(upstream_connect_allow, 1'b0)
      i_cfg_agent.wr(8'hF8, 8'h02);
      i_cfg_agent.rd(8'hF8, d);
      `CHK(d, 8'h01)
      i_cfg_agent.mode(1'b0);
      repeat (4) @(posedge clk_sys);
      i_cfg_agent.rd(8'hF8, d);
      `CHK(d, 8'h00)
      `CHK(upstream_connect_allow, 1'b1)
   endtask
   task automatic t_smbus;
      rst(8'h38);
      `CHK({smbus_mode, shared_power_mode, full_power_mgmt}, 3'b110)
      `CHK(port_charge_en, 4'h8)
      port_power_req = 4'h0;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK(port_power_enable, 4'hF)
      port_power_req = 4'h2;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK(port_power_enable, 4'h0)
      i_cfg_agent.mode(1'b1);
      i_cfg_agent.wr(8'hF0, 8'h5A);
      i_cfg_agent.wr(8'hF8, 8'hFC);
      i_cfg_agent.rd(8'hF8, d);
      `CHK(d, 8'h01)
      i_cfg_agent.wr(8'hF8, 8'h02);
      i_cfg_agent.rd(8'hF8, d);
      `CHK(d, 8'h03)
      for (int n = 0; n < 10 && cfg_soft_reset_pulse !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      `CHK(cfg_soft_reset_pulse, 1'b1)
      i_cfg_agent.rd(8'hF0, d);
      `CHK(d, 8'h00)
      i_cfg_agent.rd(8'hF8, d);
      `CHK(d, 8'h01)
      i_cfg_agent.wr(8'hF0, 8'h5A);
      i_cfg_agent.rd(8'h10, d);
      `CHK(d, 8'h00)
      i_cfg_agent.mode(1'b0);
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK(upstream_connect_allow, 1'b0)
      i_cfg_agent.end_cfg();
      repeat (3) @(posedge clk_sys);
      i_cfg_agent.rd(8'hF8, d);
      `CHK(d, 8'h00)
      `CHK(upstream_connect_allow, 1'b1)
      i_cfg_agent.rd(8'hF0, d);
      `CHK(d, 8'h5A)
      `CHK(user_cfg, 8'h5A)
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      resetn = 1'b0;
      {config_interface_select_n, power_switch_polarity_strap} = 2'b11;
      {shared_power_switch_strap, full_power_mgmt_strap_n} = 2'b00;
      port_charge_enable_strap = 4'h0;
      port_power_req = 4'h0;
      t_i2c();
      t_smbus();
      results();
   end
   initial begin
      #100000;
      err_total++;
      results();
   end
endmodule // test_hub_config_status_and_straps
